// [common/acfg_pkg.sv]
// Purpose: constants and types for the converter control register bank
// Assumes: 40 MHz block clock
// Notes:   times are held in tenths of a millisecond
package acfg_pkg;
    // register offsets
    localparam logic [7:0] OFS_PAGE       = 8'h00;
    localparam logic [7:0] OFS_SOFT_RESET = 8'h01;
    localparam logic [7:0] OFS_SLEEP      = 8'h02;
    localparam logic [7:0] OFS_SHDN       = 8'h05;
    localparam logic [7:0] OFS_FORMAT     = 8'h07;
    // reset values
    localparam logic [7:0] RST_PAGE       = 8'h00;
    localparam logic [7:0] RST_SLEEP      = 8'h00;
    localparam logic [3:0] RST_SHDN       = 4'h5;
    localparam logic [7:0] RST_FORMAT     = 8'h30;
    // field positions
    localparam int BIT_SOFT_RESET = 0;
    localparam int BIT_SLEEP_EXIT = 0;
    localparam int BIT_BCAST      = 2;
    localparam int POS_QCHG       = 3;
    localparam int SHDN_BITS      = 4;
    // control port addressing
    localparam logic [6:0] BCAST_ADDR = 7'h4c;
    localparam logic [4:0] ADDR_BASE  = 5'h12;
    // shutdown mode codes
    localparam logic [1:0] SHDN_OFF_NOW  = 2'h0;
    localparam logic [1:0] SHDN_TIMEOUT  = 2'h1;
    localparam logic [1:0] SHDN_CLEAN    = 2'h2;
    // durations in tenths of a millisecond, indexed by field code
    localparam logic [15:0] QCHG_TENTHS [4] = '{16'h0023, 16'h0064, 16'h01f4, 16'h03e8};
    localparam logic [15:0] KA_TENTHS   [4] = '{16'h012c, 16'h00fa, 16'h0064, 16'h0032};
    // timing
    localparam int CLK_PERIOD_NS     = 25;
    localparam int TENTH_MS_NS       = 100000;
    localparam int CYC_PER_TENTH_MS  = TENTH_MS_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [1:0] protocol;
        logic [1:0] slot_len;
        logic       fs_inv;
        logic       bclk_inv;
        logic       tx_edge;
        logic       tx_fill;
    } acfg_fmt_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] keepalive;
    } acfg_shdn_t;
endpackage

// [design/acfg_regs.sv]
// Purpose: page-0 power and serial format registers behind a two-wire control port
// Assumes: control port clock and data are sampled by clk_i through two flops
// Notes:   long timers run off a shared prescaler tick of TICK_CYCLES clocks
`timescale 1ns/1ps
`default_nettype none
module acfg_regs #(
    parameter int TICK_CYCLES = acfg_pkg::CYC_PER_TENTH_MS
) (
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output var  logic              sda_o,
    output var  logic              sda_oe_n_o,
    input  wire logic [1:0]        addr_sel_i,
    input  wire logic              shutdown_pin_n_i,
    input  wire logic              clean_done_i,
    input  wire logic              tx_bit_i,
    input  wire logic              tx_used_i,
    output var  logic              sdout_o,
    output var  logic              sdout_oe_n_o,
    output var  acfg_pkg::acfg_fmt_t fmt_o,
    output var  logic              launch_edge_o,
    output var  logic              sleep_o,
    output var  logic              ref_charge_busy_o,
    output var  logic              regulator_on_o
);
    import acfg_pkg::*;

    typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_PTR, I_WDATA, I_WACK, I_RDATA, I_RACK} acfg_i2c_t;
    typedef enum logic [1:0] {R_ON, R_KEEP, R_CLEAN, R_OFF} acfg_rstate_t;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_reg <= 5'h1f;
            sync2_reg <= 5'h1f;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            sync1_reg <= {scl_i, sda_i, shutdown_pin_n_i, addr_sel_i};
            sync2_reg <= sync1_reg;
            scl_d_reg <= sync2_reg[4];
            sda_d_reg <= sync2_reg[3];
        end
    end
    wire logic       scl_s    = sync2_reg[4];
    wire logic       sda_s    = sync2_reg[3];
    wire logic       shdn_s   = ~sync2_reg[2];
    wire logic [1:0] apin_s   = sync2_reg[1:0];
    wire logic       scl_rise = scl_s & ~scl_d_reg;
    wire logic       scl_fall = ~scl_s & scl_d_reg;
    wire logic       start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire logic       stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    ////////////////////////////////////////////////////////////////////////
    // register storage and decode
    logic [7:0]  page_reg;
    logic        soft_reset_reg;
    logic [7:0]  sleep_reg;
    acfg_shdn_t  shdn_reg;
    acfg_fmt_t   fmt_reg;
    logic [7:0]  ptr_reg;
    logic [7:0]  wdata_reg;
    logic        wr_reg;

    wire logic       page0    = (page_reg == 8'h00);
    wire logic       wr_page  = wr_reg & (ptr_reg == OFS_PAGE);
    wire logic       wr_reset = wr_reg & page0 & (ptr_reg == OFS_SOFT_RESET);
    wire logic       wr_sleep = wr_reg & page0 & (ptr_reg == OFS_SLEEP);
    wire logic       wr_shdn  = wr_reg & page0 & (ptr_reg == OFS_SHDN);
    wire logic       wr_fmt   = wr_reg & page0 & (ptr_reg == OFS_FORMAT);
    wire logic       bcast    = sleep_reg[BIT_BCAST];
    wire logic       sleep_exit = sleep_reg[BIT_SLEEP_EXIT];
    wire logic [1:0] qchg     = sleep_reg[POS_QCHG +: 2];
    // read-only reserved positions are masked to their reset value
    wire logic [7:0] rd_data  = (ptr_reg == OFS_PAGE)                ? page_reg :
                                (!page0)                             ? 8'h00 :
                                (ptr_reg == OFS_SLEEP)               ? {sleep_reg[7:2], 1'b0, sleep_reg[0]} :
                                (ptr_reg == OFS_SHDN)                ? {4'h0, shdn_reg} :
                                (ptr_reg == OFS_FORMAT)              ? fmt_reg :
                                8'h00;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            page_reg       <= RST_PAGE;
            soft_reset_reg <= 1'b0;
            sleep_reg      <= RST_SLEEP;
            shdn_reg       <= RST_SHDN;
            fmt_reg        <= RST_FORMAT;
        end else if (soft_reset_reg) begin
            page_reg       <= RST_PAGE;
            soft_reset_reg <= 1'b0;
            sleep_reg      <= RST_SLEEP;
            shdn_reg       <= RST_SHDN;
            fmt_reg        <= RST_FORMAT;
        end else begin
            soft_reset_reg <= wr_reset & wdata_reg[BIT_SOFT_RESET];
            if (wr_page) page_reg <= wdata_reg;
            if (wr_sleep) sleep_reg <= {wdata_reg[7:2], 1'b0, wdata_reg[0]};
            if (wr_shdn) shdn_reg <= wdata_reg[SHDN_BITS-1:0];
            if (wr_fmt) fmt_reg <= wdata_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-wire control port slave
    acfg_i2c_t  ist_reg;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic       rw_reg;
    logic       oe_n_reg;
    wire logic [6:0] my_addr  = bcast ? BCAST_ADDR : {ADDR_BASE, apin_s};
    wire logic       addr_hit = (shift_reg[7:1] == my_addr);
    wire logic       byte_end = scl_fall & (cnt_reg == 4'h8);
    wire logic [2:0] tx_idx   = 3'(4'h7 - cnt_reg);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ist_reg <= I_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            rw_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            ptr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            wr_reg <= 1'b0;
        end else begin
            wr_reg <= 1'b0;
            if (scl_rise && ist_reg != I_RACK) begin
                shift_reg <= {shift_reg[6:0], sda_s};
                cnt_reg <= cnt_reg + 4'h1;
            end
            if (start_ev) begin
                ist_reg <= I_ADDR;
                cnt_reg <= 4'h0;
                oe_n_reg <= 1'b1;
            end else if (stop_ev) begin
                ist_reg <= I_IDLE;
                oe_n_reg <= 1'b1;
            end else begin
                case (ist_reg)
                    I_ADDR: if (byte_end) begin
                        cnt_reg <= 4'h0;
                        rw_reg <= shift_reg[0];
                        oe_n_reg <= ~addr_hit;
                        ist_reg <= addr_hit ? I_AACK : I_IDLE;
                    end
                    I_AACK: if (scl_fall) begin
                        // the ack clock pulse was counted, so restart the bit count
                        cnt_reg <= 4'h0;
                        tx_reg <= rd_data;
                        oe_n_reg <= rw_reg ? rd_data[7] : 1'b1;
                        ist_reg <= rw_reg ? I_RDATA : I_PTR;
                    end
                    I_PTR: if (byte_end) begin
                        cnt_reg <= 4'h0;
                        ptr_reg <= shift_reg;
                        oe_n_reg <= 1'b0;
                        ist_reg <= I_WACK;
                    end
                    I_WDATA: if (byte_end) begin
                        cnt_reg <= 4'h0;
                        wdata_reg <= shift_reg;
                        wr_reg <= 1'b1;
                        oe_n_reg <= 1'b0;
                        ist_reg <= I_WACK;
                    end
                    I_WACK: if (scl_fall) begin
                        cnt_reg <= 4'h0;
                        oe_n_reg <= 1'b1;
                        ist_reg <= I_WDATA;
                    end
                    I_RDATA: if (scl_fall) begin
                        if (cnt_reg == 4'h8) begin
                            cnt_reg <= 4'h0;
                            // step early so the next byte's data is ready at the ack fall
                            ptr_reg <= ptr_reg + 8'h01;
                            oe_n_reg <= 1'b1;
                            ist_reg <= I_RACK;
                        end else begin
                            oe_n_reg <= tx_reg[tx_idx];
                        end
                    end
                    I_RACK: begin
                        if (scl_rise && sda_s) ist_reg <= I_IDLE;
                        if (scl_fall) begin
                            tx_reg <= rd_data;
                            oe_n_reg <= rd_data[7];
                            ist_reg <= I_RDATA;
                        end
                    end
                    default: ist_reg <= I_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler, reference charge timer and regulator control
    logic [12:0]  pre_reg;
    logic [15:0]  chg_reg;
    logic [15:0]  ka_reg;
    logic         sleep_exit_d_reg;
    acfg_rstate_t rst_reg;
    wire logic tick = (pre_reg == 13'(TICK_CYCLES - 1));

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_reg <= 13'h0000;
            chg_reg <= 16'h0000;
            sleep_exit_d_reg <= 1'b0;
        end else begin
            pre_reg <= tick ? 13'h0000 : pre_reg + 13'h0001;
            sleep_exit_d_reg <= sleep_exit;
            if (sleep_exit && !sleep_exit_d_reg) chg_reg <= QCHG_TENTHS[qchg];
            else if (!sleep_exit) chg_reg <= 16'h0000;
            else if (tick && chg_reg != 16'h0000) chg_reg <= chg_reg - 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_reg <= R_ON;
            ka_reg <= 16'h0000;
        end else begin
            case (rst_reg)
                R_ON: if (shdn_s) begin
                    ka_reg <= KA_TENTHS[shdn_reg.keepalive];
                    if (shdn_reg.mode == SHDN_OFF_NOW) rst_reg <= R_OFF;
                    else if (shdn_reg.mode == SHDN_CLEAN) rst_reg <= R_CLEAN;
                    else rst_reg <= R_KEEP;
                end
                R_KEEP: begin
                    if (!shdn_s) rst_reg <= R_ON;
                    else if (ka_reg == 16'h0000) rst_reg <= R_OFF;
                    else if (tick) ka_reg <= ka_reg - 16'h0001;
                end
                R_CLEAN: begin
                    if (!shdn_s) rst_reg <= R_ON;
                    else if (clean_done_i) rst_reg <= R_OFF;
                end
                R_OFF: if (!shdn_s) rst_reg <= R_ON;
                default: rst_reg <= R_ON;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output flops
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sda_o <= 1'b0;
            sda_oe_n_o <= 1'b1;
            sdout_o <= 1'b0;
            sdout_oe_n_o <= 1'b0;
            fmt_o <= RST_FORMAT;
            launch_edge_o <= 1'b0;
            sleep_o <= 1'b1;
            ref_charge_busy_o <= 1'b0;
            regulator_on_o <= 1'b1;
        end else begin
            sda_o <= 1'b0;
            sda_oe_n_o <= oe_n_reg;
            sdout_o <= tx_used_i & tx_bit_i;
            sdout_oe_n_o <= ~tx_used_i & fmt_reg.tx_fill;
            fmt_o <= fmt_reg;
            launch_edge_o <= fmt_reg.bclk_inv ^ fmt_reg.tx_edge;
            sleep_o <= ~sleep_exit;
            ref_charge_busy_o <= (chg_reg != 16'h0000);
            regulator_on_o <= (rst_reg != R_OFF);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    soft_clear_a:   assert property (soft_reset_reg |=> !soft_reset_reg) else $error("soft reset stuck");
    soft_default_a: assert property (soft_reset_reg |=> fmt_reg == RST_FORMAT && shdn_reg == RST_SHDN
                        && sleep_reg == RST_SLEEP && page_reg == RST_PAGE) else $error("defaults lost");
    rsv_read_a:     assert property (ptr_reg == OFS_SHDN && page0 |-> rd_data[7:4] == 4'h0)
                        else $error("reserved bits nonzero");
    sleep_out_a:    assert property (!sleep_exit |=> sleep_o) else $error("sleep not shown");
    bcast_ack_a:    assert property (ist_reg == I_ADDR && byte_end && bcast && shift_reg[7:1] == BCAST_ADDR
                        |=> ist_reg == I_AACK ##1 !sda_oe_n_o) else $error("broadcast not acked");
    off_now_a:      assert property (rst_reg == R_ON && shdn_s && shdn_reg.mode == SHDN_OFF_NOW
                        |-> ##2 !regulator_on_o) else $error("regulator not off");
    keep_on_a:      assert property (rst_reg == R_KEEP |=> regulator_on_o) else $error("keepalive dropped");
    charge_go_a:    assert property ($rose(sleep_exit) |-> ##2 ref_charge_busy_o) else $error("charge idle");
    fmt_out_a:      assert property (##1 fmt_o == $past(fmt_reg)) else $error("format lag");
    edge_sel_a:     assert property (##1 launch_edge_o == $past(fmt_reg.bclk_inv ^ fmt_reg.tx_edge))
                        else $error("launch edge wrong");
    fill_hiz_a:     assert property (!tx_used_i && fmt_reg.tx_fill |=> sdout_oe_n_o) else $error("fill not hiz");
    fill_zero_a:    assert property (!tx_used_i && !fmt_reg.tx_fill |=> !sdout_oe_n_o && !sdout_o)
                        else $error("fill not zero");
    page_gate_a:    assert property (wr_reg && !page0 && ptr_reg == OFS_FORMAT |=> $stable(fmt_reg))
                        else $error("write off page");

    soft_cov_c:     cover property (wr_reset ##1 soft_reset_reg);
    read_cov_c:     cover property (ist_reg == I_RACK ##[1:400] ist_reg == I_RDATA);
    keep_cov_c:     cover property (rst_reg == R_KEEP ##[1:1000] rst_reg == R_OFF);
    clean_cov_c:    cover property (rst_reg == R_CLEAN ##1 rst_reg == R_OFF);
endmodule // acfg_regs
`default_nettype wire

// [verif/acfg_host.sv]
// Purpose: host model on the two-wire control port of the register bank
// Assumes: open-drain data line with pull-up; scl half period of 8 block clocks
// Notes:   scl stands high between frames; all changes land on a clk_i rising edge
`timescale 1ns/1ps
`default_nettype none
module acfg_host (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // data set mid-low, wire sampled at the end of the high phase
    task automatic bit_io(input logic b, output logic r);
        wait_clk(4);
        sda_o <= b;
        wait_clk(4);
        scl_o <= 1'b1;
        wait_clk(8);
        r = sda_i;
        scl_o <= 1'b0;
    endtask

    // also serves as repeated start
    task automatic start_c;
        sda_o <= 1'b1;
        wait_clk(4);
        scl_o <= 1'b1;
        wait_clk(8);
        sda_o <= 1'b0;
        wait_clk(8);
        scl_o <= 1'b0;
    endtask

    task automatic stop_c;
        wait_clk(4);
        sda_o <= 1'b0;
        wait_clk(4);
        scl_o <= 1'b1;
        wait_clk(8);
        sda_o <= 1'b1;
        wait_clk(8);
    endtask

    task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack);
    endtask

    // caller keeps reserved bits at defaults and selects page zero first
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] dat, output logic ok);
        logic [7:0] rx;
        logic       a0, a1, a2;
        start_c();
        byte_io({dev, 1'b0}, 1'b1, rx, a0);
        byte_io(ofs, 1'b1, rx, a1);
        byte_io(dat, 1'b1, rx, a2);
        stop_c();
        ok = !(a0 | a1 | a2);
    endtask

    // one byte read after a pointer write, ended by nack
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] dat, output logic ok);
        logic [7:0] rx;
        logic       a0, a1, a2, a3;
        start_c();
        byte_io({dev, 1'b0}, 1'b1, rx, a0);
        byte_io(ofs, 1'b1, rx, a1);
        start_c();
        byte_io({dev, 1'b1}, 1'b1, rx, a2);
        byte_io(8'hff, 1'b1, dat, a3);
        stop_c();
        ok = !(a0 | a1 | a2);
    endtask
endmodule // acfg_host
`default_nettype wire

// [verif/testbench.sv]
// Purpose: self-checking bench for the power and serial format register bank
// Assumes: host model on the control port; TICK_CYCLES shortened to 4
// Notes:   timer spans are checked within one tick plus synchroniser slack
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import acfg_pkg::*;
    localparam int         TICK = 4;
    localparam logic [6:0] DEV  = {ADDR_BASE, 2'h1};
    localparam logic [7:0] FMTV [4] = '{8'h00, 8'h5a, 8'ha5, 8'h3e};

    logic       clk_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic [1:0] addr_sel = 2'h1;
    logic       shdn_n = 1'b1;
    logic       clean_done = 1'b0;
    logic       tx_bit = 1'b0;
    logic       tx_used = 1'b0;
    logic       scl, host_sda, sda_o, sda_oe_n, sdout, sdout_oe_n, launch_edge, sleep, busy, reg_on;
    acfg_fmt_t  fmt;
    int         n_errors = 0;
    int         n_tests = 0;
    wire logic  sda_w = host_sda & (sda_oe_n | sda_o);

    always #12.5 clk_i = ~clk_i;

    acfg_regs #(.TICK_CYCLES(TICK)) i_acfg_regs (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .addr_sel_i(addr_sel), .shutdown_pin_n_i(shdn_n),
        .clean_done_i(clean_done), .tx_bit_i(tx_bit), .tx_used_i(tx_used), .sdout_o(sdout),
        .sdout_oe_n_o(sdout_oe_n), .fmt_o(fmt), .launch_edge_o(launch_edge), .sleep_o(sleep),
        .ref_charge_busy_o(busy), .regulator_on_o(reg_on));
    acfg_host i_acfg_host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic near(input int n, input int e);
        check((n >= e - TICK - 6 && n <= e + TICK + 6) ? 16'(e) : 16'(n), 16'(e));
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
        logic ok;
        i_acfg_host.write_reg(DEV, ofs, dat, ok);
        check(ok, 1'b1);
    endtask

    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        i_acfg_host.read_reg(DEV, ofs, d, ok);
        check({ok, d}, {1'b1, exp});
    endtask

    // counts cycles that s holds lvl, after first waiting for it
    task automatic span(ref logic s, input logic lvl, output int n);
        n = 0;
        while (s !== lvl && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        while (s === lvl && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    task automatic check_defaults;
        rd(8'h01, 8'h00);
        rd(8'h02, RST_SLEEP);
        rd(8'h05, {4'h0, RST_SHDN});
        rd(8'h07, RST_FORMAT);
        check(fmt, RST_FORMAT);
        check(sleep, 1'b1);
    endtask

    task automatic print_verdict;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        logic       ok;
        int         n;
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        check_defaults();
        rd(8'h03, 8'h00);
        foreach (FMTV[k]) begin
            wr(8'h07, FMTV[k]);
            rd(8'h07, FMTV[k]);
            check(fmt, FMTV[k]);
            check(launch_edge, FMTV[k][2] ^ FMTV[k][1]);
            tx_used <= 1'b0;
            tx_bit <= 1'b1;
            repeat (3) @(posedge clk_i);
            check({sdout_oe_n, sdout}, {FMTV[k][0], 1'b0});
            tx_used <= 1'b1;
            repeat (3) @(posedge clk_i);
            check({sdout_oe_n, sdout}, 2'b01);
        end
        wr(8'h00, 8'h01);
        i_acfg_host.write_reg(DEV, 8'h07, 8'h00, ok);
        rd(8'h07, 8'h00);
        check(fmt, 8'h3e);
        wr(8'h00, 8'h00);
        rd(8'h07, 8'h3e);
        wr(8'h02, 8'h04);
        i_acfg_host.read_reg(DEV, 8'h02, d, ok);
        check(ok, 1'b0);
        i_acfg_host.read_reg(BCAST_ADDR, 8'h02, d, ok);
        check({ok, d}, 9'h104);
        i_acfg_host.write_reg(BCAST_ADDR, 8'h02, 8'h00, ok);
        rd(8'h02, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(8'h02, 8'h00);
            fork
                wr(8'h02, {3'h0, 2'(c), 3'h1});
                span(busy, 1'b1, n);
            join
            near(n, QCHG_TENTHS[c] * TICK);
            check(sleep, 1'b0);
        end
        for (int c = 0; c < 4; c++) begin
            wr(8'h05, {4'h0, SHDN_TIMEOUT, 2'(c)});
            shdn_n <= 1'b0;
            span(reg_on, 1'b1, n);
            near(n, KA_TENTHS[c] * TICK + 5);
            shdn_n <= 1'b1;
            repeat (8) @(posedge clk_i);
            check(reg_on, 1'b1);
        end
        wr(8'h05, {4'h0, SHDN_OFF_NOW, 2'h1});
        shdn_n <= 1'b0;
        span(reg_on, 1'b1, n);
        near(n, 5);
        shdn_n <= 1'b1;
        wr(8'h05, {4'h0, SHDN_CLEAN, 2'h3});
        shdn_n <= 1'b0;
        repeat (400) @(posedge clk_i);
        check(reg_on, 1'b1);
        clean_done <= 1'b1;
        span(reg_on, 1'b1, n);
        near(n, 2);
        shdn_n <= 1'b1;
        clean_done <= 1'b0;
        wr(8'h01, 8'h01);
        check_defaults();
        print_verdict();
    end

    initial begin
        repeat (90000) @(posedge clk_i);
        n_errors++;
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
